/* rtl/sld_pkg.sv */
// Constants, register map and level helper for the segment LCD driver
package sld_pkg;

    // Geometry
    localparam int SLD_NUM_COM = 6;
    localparam int SLD_NUM_SEG = 38;

    // Timing: system clock and slow clock
    localparam int SLD_CLK_PERIOD_NS = 5;
    localparam int SLD_SLOW_CLK_HZ = 32000;
    localparam int SLD_SLOW_PERIOD_NS = 1000000000 / SLD_SLOW_CLK_HZ;
    localparam int SLD_SLOW_DIV_CYC = SLD_SLOW_PERIOD_NS / SLD_CLK_PERIOD_NS;

    // Frame prescaler: 8 << select, select 0..7
    localparam logic [10:0] SLD_FRAME_PRESCALER_BASE = 11'h008;

    // Uniformizer divider per common count (1..6 commons)
    localparam logic [4:0] SLD_UNIF_DIV [SLD_NUM_COM] = '{
        5'h10, 5'h08, 5'h05, 5'h04, 5'h03, 5'h03
    };

    // Register offsets (byte addresses)
    localparam logic [7:0] SLD_OFS_CTRL = 8'h00;
    localparam logic [7:0] SLD_OFS_MODE = 8'h04;
    localparam logic [7:0] SLD_OFS_FRAME_RATE = 8'h08;
    localparam logic [7:0] SLD_OFS_STATUS = 8'h0C;
    localparam logic [7:0] SLD_OFS_REMAP0 = 8'h10;
    localparam logic [7:0] SLD_OFS_REMAP1 = 8'h14;
    localparam logic [7:0] SLD_OFS_INT_EN = 8'h18;
    localparam logic [7:0] SLD_OFS_INT_FLAG = 8'h1C;
    localparam logic [7:0] SLD_OFS_MEM = 8'h20;
    localparam logic [7:0] SLD_MEM_STRIDE = 8'h08;

    // Mode register fields
    localparam int SLD_MODE_COM_LSB = 0;
    localparam int SLD_MODE_SEG_LSB = 8;
    localparam int SLD_MODE_BIAS_LSB = 16;
    localparam int SLD_MODE_BUF_LSB = 20;

    // Frame rate register fields
    localparam int SLD_FRR_FRAME_PRESCALER_LSB = 0;
    localparam int SLD_FRR_DIV_LSB = 8;

    // Interrupt cause bits
    localparam int SLD_INT_FRAME = 0;
    localparam int SLD_INT_DISABLE = 1;

    // Reset values
    localparam logic [2:0] SLD_RST_COM_SEL = 3'h0;
    localparam logic [5:0] SLD_RST_SEG_SEL = 6'h00;
    localparam logic [3:0] SLD_RST_BUF_TIME = 4'hF;
    localparam logic [2:0] SLD_RST_FRAME_PRESCALER = 3'h0;
    localparam logic [2:0] SLD_RST_DIV = 3'h0;

    typedef enum logic [1:0] {
        SLD_BIAS_STATIC,
        SLD_BIAS_HALF,
        SLD_BIAS_THIRD
    } sld_bias_t;

    // Level code k means k / N of the LCD supply, N = levels - 1:
    // N is 1, 2 or 3 for static, half and third bias
    function automatic logic [1:0] sld_level(
        input logic drive,
        input logic pol,
        input logic is_com,
        input sld_bias_t bias
    );
        logic [1:0] n;
        n = (bias == SLD_BIAS_THIRD) ? 2'h3 :
            (bias == SLD_BIAS_HALF) ? 2'h2 : 2'h1;
        if (drive != is_com) begin
            // Energized segment, or unselected common
            if (is_com && bias == SLD_BIAS_THIRD)
                sld_level = pol ? 2'h1 : 2'h2;
            else if (is_com && bias == SLD_BIAS_HALF)
                sld_level = 2'h1;
            else
                sld_level = is_com ? (pol ? n : 2'h0) : (pol ? 2'h0 : n);
        end else if (!is_com && bias == SLD_BIAS_THIRD) begin
            sld_level = pol ? 2'h2 : 2'h1;
        end else begin
            // Selected common, or dark segment in static/half bias
            sld_level = pol ? n : 2'h0;
        end
    endfunction

endpackage

/* rtl/sld_seg_cell.sv */
// One segment pin: level and enable registers
`timescale 1ns/1ps
module sld_seg_cell
    import sld_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Drive request
    input wire logic run,
    input wire logic data_bit,
    input wire logic pol,
    input sld_bias_t bias,
    input wire logic pin_sel,
    // Pin
    output logic [1:0] level_ff,
    output logic oe_ff
);

    logic [1:0] nxt_level;
    logic nxt_oe;

    always_comb begin
        nxt_oe = run & pin_sel;
        nxt_level = nxt_oe ? sld_level(data_bit, pol, 1'b0, bias) : 2'h0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_ff <= 2'h0;
            oe_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            oe_ff <= nxt_oe;
        end
    end

endmodule

/* rtl/sld_driver.sv */
// Segment LCD driver: registers, frame timing and pin drive
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Drive up to six commons, 38 segments
// - Polarity alternates every frame, no DC
// - Static up to one-sixth duty supported
// - Static, half or third bias selectable
// - Duty follows configured common count
// - Level count equals bias denominator plus one
// - Causes: frame done, disable done
// - Zero remap: lowest pins carry segments
// - Nonzero remap: set bits select pins
// - All timing from slow clock tick
// - Single interrupt request line out
// - Software writes never disturb driven row
// - One common, one segment works
// - Buffer drive time programmable
// - Prescaler 8..1024 then divider 1..8
// - Uniformizer 16,8,5,4,3,3 by commons
// - Bit one energizes, zero leaves dark
// - Row copied at each common slot start
module sld_driver
    import sld_pkg::*;
#(
    parameter int NUM_COM = SLD_NUM_COM,
    parameter int NUM_SEG = SLD_NUM_SEG,
    parameter int SLOW_DIV = SLD_SLOW_DIV_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Panel pins
    output logic [2*NUM_COM-1:0] common_pin_level,
    output logic [NUM_COM-1:0] common_pin_oe,
    output logic [2*NUM_SEG-1:0] segment_pin_level,
    output logic [NUM_SEG-1:0] segment_pin_oe,
    output logic [1:0] lcd_bias,
    output logic buffer_drive_en,
    // Interrupt
    output logic irq
);

    localparam int HI_W = NUM_SEG - 32;

    // Software registers
    logic enable_ff, nxt_enable;
    logic [2:0] common_count_select_ff, nxt_common_count_select;
    logic [5:0] segment_count_select_ff, nxt_segment_count_select;
    sld_bias_t bias_ff, nxt_bias;
    logic [3:0] buffer_drive_time_ff, nxt_buffer_drive_time;
    logic [2:0] frame_prescaler_ff, nxt_frame_prescaler;
    logic [2:0] fine_div_ff, nxt_fine_div;
    logic [NUM_SEG-1:0] segment_remap_regs_ff, nxt_segment_remap_regs;
    logic [1:0] int_en_ff, nxt_int_en;
    logic [1:0] int_flag_ff, nxt_int_flag;
    logic [NUM_SEG-1:0] user_buf_ff [NUM_COM];
    logic [NUM_SEG-1:0] nxt_user_buf [NUM_COM];
    logic [31:0] rdata_ff, nxt_rdata;

    // Frame timing state
    logic [15:0] slow_cnt_ff, nxt_slow_cnt;
    logic [10:0] pre_cnt_ff, nxt_pre_cnt;
    logic [2:0] div_cnt_ff, nxt_div_cnt;
    logic [4:0] unif_cnt_ff, nxt_unif_cnt;
    logic [2:0] com_ff, nxt_com;
    logic pol_ff, nxt_pol;
    logic run_ff, nxt_run;
    logic [3:0] buf_cnt_ff, nxt_buf_cnt;
    logic [NUM_SEG-1:0] frame_row_ff, nxt_frame_row;

    // Decode
    logic mem_hit;
    logic [2:0] mem_idx;
    logic [7:0] mem_ofs;
    logic [2:0] com_last;
    logic [10:0] frame_prescaler_last;
    logic [4:0] unif_last;
    logic slow_tick, pre_end, div_end, slot_end, frame_end, start;
    logic [NUM_SEG-1:0] pin_sel;
    logic [1:0] events;

    assign mem_ofs = reg_addr - SLD_OFS_MEM;
    assign mem_idx = mem_ofs[5:3];
    assign mem_hit = (reg_addr >= SLD_OFS_MEM) && (mem_ofs[1:0] == 2'h0)
        && (int'(mem_idx) < NUM_COM) && (mem_ofs[7:6] == 2'h0);

    // Clamp common selection to the supported range
    assign com_last = (int'(common_count_select_ff) < NUM_COM) ?
        common_count_select_ff : 3'(NUM_COM - 1);

    // Register write and read
    always_comb begin
        nxt_enable = enable_ff;
        nxt_common_count_select = common_count_select_ff;
        nxt_segment_count_select = segment_count_select_ff;
        nxt_bias = bias_ff;
        nxt_buffer_drive_time = buffer_drive_time_ff;
        nxt_frame_prescaler = frame_prescaler_ff;
        nxt_fine_div = fine_div_ff;
        nxt_segment_remap_regs = segment_remap_regs_ff;
        nxt_int_en = int_en_ff;
        nxt_user_buf = user_buf_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                SLD_OFS_CTRL: nxt_enable = reg_wdata[0];
                SLD_OFS_MODE: begin
                    nxt_common_count_select =
                        reg_wdata[SLD_MODE_COM_LSB +: 3];
                    nxt_segment_count_select =
                        reg_wdata[SLD_MODE_SEG_LSB +: 6];
                    nxt_bias = (reg_wdata[SLD_MODE_BIAS_LSB +: 2] == 2'h3) ?
                        SLD_BIAS_THIRD :
                        sld_bias_t'(reg_wdata[SLD_MODE_BIAS_LSB +: 2]);
                    nxt_buffer_drive_time =
                        reg_wdata[SLD_MODE_BUF_LSB +: 4];
                end
                SLD_OFS_FRAME_RATE: begin
                    nxt_frame_prescaler = reg_wdata[SLD_FRR_FRAME_PRESCALER_LSB +: 3];
                    nxt_fine_div = reg_wdata[SLD_FRR_DIV_LSB +: 3];
                end
                SLD_OFS_REMAP0: nxt_segment_remap_regs[31:0] = reg_wdata;
                SLD_OFS_REMAP1:
                    nxt_segment_remap_regs[NUM_SEG-1:32] = reg_wdata[HI_W-1:0];
                SLD_OFS_INT_EN: nxt_int_en = reg_wdata[1:0];
                default: begin
                    // Only the user buffer is written; the driven row
                    // changes at slot boundaries alone
                    if (mem_hit && !mem_ofs[2])
                        nxt_user_buf[mem_idx][31:0] = reg_wdata;
                    else if (mem_hit)
                        nxt_user_buf[mem_idx][NUM_SEG-1:32] =
                            reg_wdata[HI_W-1:0];
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                SLD_OFS_CTRL: nxt_rdata = {31'h0, enable_ff};
                SLD_OFS_MODE: nxt_rdata = {8'h00, buffer_drive_time_ff,
                    2'h0, bias_ff, 2'h0, segment_count_select_ff,
                    5'h00, common_count_select_ff};
                SLD_OFS_FRAME_RATE:
                    nxt_rdata = {21'h0, fine_div_ff, 5'h00, frame_prescaler_ff};
                SLD_OFS_STATUS:
                    nxt_rdata = {15'h0, pol_ff, 5'h00, com_ff, 7'h00, run_ff};
                SLD_OFS_REMAP0: nxt_rdata = segment_remap_regs_ff[31:0];
                SLD_OFS_REMAP1: nxt_rdata =
                    {{(64-NUM_SEG){1'b0}}, segment_remap_regs_ff[NUM_SEG-1:32]};
                SLD_OFS_INT_EN: nxt_rdata = {30'h0, int_en_ff};
                SLD_OFS_INT_FLAG: nxt_rdata = {30'h0, int_flag_ff};
                default: begin
                    if (mem_hit && !mem_ofs[2])
                        nxt_rdata = user_buf_ff[mem_idx][31:0];
                    else if (mem_hit)
                        nxt_rdata = {{(64-NUM_SEG){1'b0}},
                            user_buf_ff[mem_idx][NUM_SEG-1:32]};
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_ff <= 1'b0;
            common_count_select_ff <= SLD_RST_COM_SEL;
            segment_count_select_ff <= SLD_RST_SEG_SEL;
            bias_ff <= SLD_BIAS_STATIC;
            buffer_drive_time_ff <= SLD_RST_BUF_TIME;
            frame_prescaler_ff <= SLD_RST_FRAME_PRESCALER;
            fine_div_ff <= SLD_RST_DIV;
            segment_remap_regs_ff <= '0;
            int_en_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
            for (int i = 0; i < NUM_COM; i++) begin
                user_buf_ff[i] <= '0;
            end
        end else begin
            enable_ff <= nxt_enable;
            common_count_select_ff <= nxt_common_count_select;
            segment_count_select_ff <= nxt_segment_count_select;
            bias_ff <= nxt_bias;
            buffer_drive_time_ff <= nxt_buffer_drive_time;
            frame_prescaler_ff <= nxt_frame_prescaler;
            fine_div_ff <= nxt_fine_div;
            segment_remap_regs_ff <= nxt_segment_remap_regs;
            int_en_ff <= nxt_int_en;
            rdata_ff <= nxt_rdata;
            user_buf_ff <= nxt_user_buf;
        end
    end

    assign reg_rdata = rdata_ff;

    // Frame timing chain
    assign frame_prescaler_last = (SLD_FRAME_PRESCALER_BASE << frame_prescaler_ff) - 11'h001;
    assign unif_last = SLD_UNIF_DIV[com_last] - 5'h01;
    assign slow_tick = (slow_cnt_ff == 16'(SLOW_DIV - 1));
    assign pre_end = run_ff && slow_tick && (pre_cnt_ff >= frame_prescaler_last);
    assign div_end = pre_end && (div_cnt_ff >= fine_div_ff);
    assign slot_end = div_end && (unif_cnt_ff >= unif_last);
    assign frame_end = slot_end && (com_ff >= com_last);
    assign start = !run_ff && enable_ff && slow_tick;

    always_comb begin
        nxt_slow_cnt = slow_tick ? 16'h0000 : slow_cnt_ff + 16'h0001;
        nxt_pre_cnt = pre_cnt_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_unif_cnt = unif_cnt_ff;
        nxt_com = com_ff;
        nxt_pol = pol_ff;
        nxt_run = run_ff;
        nxt_frame_row = frame_row_ff;
        nxt_buf_cnt = buf_cnt_ff;
        if (run_ff && slow_tick && buf_cnt_ff != 4'hF)
            nxt_buf_cnt = buf_cnt_ff + 4'h1;
        if (start) begin
            nxt_run = 1'b1;
            nxt_pre_cnt = 11'h000;
            nxt_div_cnt = 3'h0;
            nxt_unif_cnt = 5'h00;
            nxt_com = 3'h0;
            nxt_pol = 1'b0;
            nxt_buf_cnt = 4'h0;
            nxt_frame_row = user_buf_ff[0];
        end else if (run_ff && slow_tick) begin
            nxt_pre_cnt = pre_end ? 11'h000 : pre_cnt_ff + 11'h001;
            if (pre_end)
                nxt_div_cnt = div_end ? 3'h0 : div_cnt_ff + 3'h1;
            if (div_end)
                nxt_unif_cnt = slot_end ? 5'h00 : unif_cnt_ff + 5'h01;
            if (slot_end) begin
                nxt_com = frame_end ? 3'h0 : com_ff + 3'h1;
                nxt_frame_row = user_buf_ff[nxt_com];
                nxt_buf_cnt = 4'h0;
            end
            if (frame_end) begin
                nxt_pol = !pol_ff;
                // A disable request takes effect only at frame end,
                // so the panel never sees a half frame of one polarity
                nxt_run = enable_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slow_cnt_ff <= 16'h0000;
            pre_cnt_ff <= 11'h000;
            div_cnt_ff <= 3'h0;
            unif_cnt_ff <= 5'h00;
            com_ff <= 3'h0;
            pol_ff <= 1'b0;
            run_ff <= 1'b0;
            buf_cnt_ff <= 4'h0;
            frame_row_ff <= '0;
        end else begin
            slow_cnt_ff <= nxt_slow_cnt;
            pre_cnt_ff <= nxt_pre_cnt;
            div_cnt_ff <= nxt_div_cnt;
            unif_cnt_ff <= nxt_unif_cnt;
            com_ff <= nxt_com;
            pol_ff <= nxt_pol;
            run_ff <= nxt_run;
            buf_cnt_ff <= nxt_buf_cnt;
            frame_row_ff <= nxt_frame_row;
        end
    end

    // Interrupt flags: a new event wins over a clear in the same cycle
    assign events[SLD_INT_FRAME] = frame_end;
    assign events[SLD_INT_DISABLE] = frame_end && !enable_ff;

    always_comb begin
        nxt_int_flag = int_flag_ff;
        if (reg_wr && reg_addr == SLD_OFS_INT_FLAG)
            nxt_int_flag = int_flag_ff & ~reg_wdata[1:0];
        nxt_int_flag = nxt_int_flag | events;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            int_flag_ff <= 2'h0;
        else
            int_flag_ff <= nxt_int_flag;
    end

    assign irq = |(int_flag_ff & int_en_ff);

    assign lcd_bias = bias_ff;
    assign buffer_drive_en = run_ff &&
        (buf_cnt_ff < buffer_drive_time_ff);

    // Common pins
    logic [2*NUM_COM-1:0] com_level_ff, nxt_com_level;
    logic [NUM_COM-1:0] com_oe_ff, nxt_com_oe;

    always_comb begin
        for (int c = 0; c < NUM_COM; c++) begin
            nxt_com_oe[c] = run_ff && (c <= int'(com_last));
            nxt_com_level[2*c +: 2] = nxt_com_oe[c] ?
                sld_level(com_ff == 3'(c), pol_ff, 1'b1, bias_ff) :
                2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            com_level_ff <= '0;
            com_oe_ff <= '0;
        end else begin
            com_level_ff <= nxt_com_level;
            com_oe_ff <= nxt_com_oe;
        end
    end

    assign common_pin_level = com_level_ff;
    assign common_pin_oe = com_oe_ff;

    // Segment pins
    genvar s;
    generate
        for (s = 0; s < NUM_SEG; s++) begin : g_seg
            assign pin_sel[s] = (|segment_remap_regs_ff) ?
                segment_remap_regs_ff[s] :
                (s <= int'(segment_count_select_ff));
            sld_seg_cell u_cell (
                .clk(clk),
                .sys_rst(sys_rst),
                .run(run_ff),
                .data_bit(frame_row_ff[s]),
                .pol(pol_ff),
                .bias(bias_ff),
                .pin_sel(pin_sel[s]),
                .level_ff(segment_pin_level[2*s +: 2]),
                .oe_ff(segment_pin_oe[s])
            );
        end
    endgenerate

endmodule

/* verif/sld_driver_props.sv */
// Port checker for the segment LCD driver
`timescale 1ns/1ps
module sld_props
    import sld_pkg::*;
#(
    parameter int NUM_COM = SLD_NUM_COM,
    parameter int NUM_SEG = SLD_NUM_SEG,
    parameter int SLOW_DIV = SLD_SLOW_DIV_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Panel pins
    input wire logic [2*NUM_COM-1:0] common_pin_level,
    input wire logic [NUM_COM-1:0] common_pin_oe,
    input wire logic [2*NUM_SEG-1:0] segment_pin_level,
    input wire logic [NUM_SEG-1:0] segment_pin_oe,
    input wire logic [1:0] lcd_bias,
    input wire logic buffer_drive_en,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic [2*NUM_SEG-1:0] seg_hi;
    logic [2*NUM_SEG-1:0] seg_top;
    logic [2*NUM_COM-1:0] com_hi;
    logic [1:0] wbias;
    // Upper bit of each level code, and codes equal to three
    assign seg_hi = segment_pin_level & {NUM_SEG{2'b10}};
    assign seg_top = seg_hi & (segment_pin_level << 1);
    assign com_hi = common_pin_level & {NUM_COM{2'b10}};
    assign wbias = (reg_wdata[17:16] == 2'h3) ? 2'h2 : reg_wdata[17:16];

    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not zero");
    a_unmapped_read: assert property (
        reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_bias_follow: assert property (
        reg_wr && reg_addr == SLD_OFS_MODE |=> lcd_bias == $past(wbias))
        else $error("bias does not follow write");
    a_reset_quiet: assert property (
        $fell(sys_rst) |-> !irq && common_pin_oe == '0 &&
        segment_pin_oe == '0 && reg_rdata == 32'h0)
        else $error("outputs active after reset");
    a_irq_masked: assert property (
        reg_wr && reg_addr == SLD_OFS_INT_EN && reg_wdata[1:0] == 2'h0
        |=> !irq) else $error("irq while all causes masked");
    a_static_two: assert property (
        lcd_bias == 2'h0 && $past(lcd_bias) == 2'h0 |->
        seg_hi == '0 && com_hi == '0) else $error("static uses third level");
    a_half_three: assert property (
        lcd_bias == 2'h1 && $past(lcd_bias) == 2'h1 |-> seg_top == '0)
        else $error("half bias uses fourth level");
    a_oe_pair: assert property (
        common_pin_oe == '0 |-> segment_pin_oe == '0)
        else $error("segment driven while commons idle");

    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
    c_irq: cover property ($rose(irq));
    c_third: cover property (lcd_bias == 2'h2 && segment_pin_oe != '0);
endmodule

bind sld_driver sld_props #(
    .NUM_COM(NUM_COM),
    .NUM_SEG(NUM_SEG),
    .SLOW_DIV(SLOW_DIV)
) u_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .common_pin_level(common_pin_level),
    .common_pin_oe(common_pin_oe),
    .segment_pin_level(segment_pin_level),
    .segment_pin_oe(segment_pin_oe),
    .lcd_bias(lcd_bias),
    .buffer_drive_en(buffer_drive_en),
    .irq(irq)
);

/* verif/sld_glass.sv */
// Passive glass model: the cell between segment 0 and common 0
`timescale 1ns/1ps
module sld_glass (
    // Clock
    input wire logic clk,
    // Electrodes
    input wire logic [1:0] seg_level,
    input wire logic [1:0] com_level,
    input wire logic [1:0] bias,
    // Cell state
    output int dc_sum,
    output logic lit
);
    int diff;
    int full;
    int acc = 0;
    assign dc_sum = acc;
    always_comb begin
        diff = int'(seg_level) - int'(com_level);
        full = bias[1] ? 3 : int'(bias) + 1;
        lit = (diff == full) || (diff == -full);
    end
    // Running sum of cell voltage, one sample per clock
    always @(posedge clk) begin
        acc <= acc + diff;
    end
endmodule

/* verif/tb_sld_driver.sv */
// Self-checking bench for the segment LCD driver
`timescale 1ns/1ps
module tb_sld_driver;
    import sld_pkg::*;
    localparam int SD = 4;
    localparam int UNIF [6] = '{16, 8, 5, 4, 3, 3};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [11:0] common_pin_level;
    logic [5:0] common_pin_oe;
    logic [75:0] segment_pin_level;
    logic [37:0] segment_pin_oe;
    logic [1:0] lcd_bias;
    logic buffer_drive_en;
    logic irq;
    logic lit;
    int dc_sum, err_count = 0, checks = 0, cyc = 0, bcnt = 0;
    int t_last, t_prev, b_last, b_prev, dc_last, dc_prev, dc_pp;

    always #2.5 clk = ~clk;

    sld_driver #(.SLOW_DIV(SD)) DUT (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .common_pin_level(common_pin_level),
        .common_pin_oe(common_pin_oe),
        .segment_pin_level(segment_pin_level),
        .segment_pin_oe(segment_pin_oe),
        .lcd_bias(lcd_bias),
        .buffer_drive_en(buffer_drive_en),
        .irq(irq)
    );

    sld_glass u_glass (
        .clk(clk),
        .seg_level(segment_pin_level[1:0]),
        .com_level(common_pin_level[1:0]),
        .bias(lcd_bias),
        .dc_sum(dc_sum),
        .lit(lit)
    );

    // Cycle count, buffer drive count and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (buffer_drive_en === 1'b1) bcnt <= bcnt + 1;
        if (cyc == 50000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [75:0] seen,
                       input logic [75:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask

    // Waits for the frame interrupt, logs timing and cell sum, clears flags
    task automatic wait_frame();
        do begin
            @(posedge clk);
            #1;
        end while (irq !== 1'b1);
        t_prev = t_last;
        t_last = cyc;
        b_prev = b_last;
        b_last = bcnt;
        @(posedge clk);
        #1;
        dc_pp = dc_prev;
        dc_prev = dc_last;
        dc_last = dc_sum;
        wr(SLD_OFS_INT_FLAG, 32'h3);
    endtask

    task automatic t_regs();
        rchk(SLD_OFS_MODE, 32'h00F00000, "mode reset");
        rchk(8'hFC, 32'h0, "unmapped");
        rchk(SLD_OFS_INT_FLAG, 32'h0, "flag reset");
        wr(SLD_OFS_INT_EN, 32'hFFFFFFFF);
        rchk(SLD_OFS_INT_EN, 32'h3, "two causes");
        chk("irq idle", irq, 1'b0);
    endtask

    task automatic t_static();
        wr(SLD_OFS_MODE, 32'h0);
        wr(SLD_OFS_FRAME_RATE, 32'h0);
        wr(SLD_OFS_MEM, 32'h1);
        wr(SLD_OFS_INT_EN, 32'h1);
        wr(SLD_OFS_CTRL, 32'h1);
        wait_frame();
        chk("com oe", common_pin_oe, 6'h01);
        chk("seg oe", segment_pin_oe, 38'h1);
        chk("cell on", lit, 1'b1);
        wr(SLD_OFS_MEM, 32'h0);
        // Give a row that is not latched time to reach the pins
        repeat (3) @(posedge clk);
        #1;
        chk("latched", lit, 1'b1);
        wait_frame();
        chk("reloaded", lit, 1'b0);
        chk("frame 1", t_last - t_prev, 8 * 16 * SD);
    endtask

    task automatic t_commons();
        for (int n = 1; n <= 6; n++) begin
            wr(SLD_OFS_MODE, 32'h00010900 | 32'(n - 1));
            repeat (3) wait_frame();
            chk("frame n", t_last - t_prev, 8 * UNIF[n - 1] * n * SD);
            chk("com oe n", common_pin_oe, 6'h3F >> (6 - n));
        end
    endtask

    task automatic t_third();
        wr(SLD_OFS_FRAME_RATE, 32'h00000101);
        wr(SLD_OFS_MODE, 32'h00220902);
        wr(SLD_OFS_MEM, 32'h1);
        repeat (4) wait_frame();
        chk("bias", lcd_bias, 2'h2);
        chk("seg oe 10", segment_pin_oe, 38'h3FF);
        chk("frame 3", t_last - t_prev, 16 * 2 * 5 * 3 * SD);
        chk("buf time", b_last - b_prev, 2 * SD * 3);
        chk("dc pair", dc_last - dc_pp, 0);
    endtask

    task automatic t_remap_off();
        wr(SLD_OFS_REMAP0, 32'h5);
        wr(SLD_OFS_REMAP1, 32'h1);
        wr(SLD_OFS_INT_EN, 32'h0);
        repeat (2 * 1920 + 8) @(posedge clk);
        #1;
        chk("remap oe", segment_pin_oe, 38'h1_0000_0005);
        chk("irq masked", irq, 1'b0);
        rchk(SLD_OFS_INT_FLAG, 32'h1, "frame flag");
        wr(SLD_OFS_INT_EN, 32'h2);
        wr(SLD_OFS_CTRL, 32'h0);
        wait_frame();
        chk("off com", common_pin_oe, 6'h0);
        chk("off seg", segment_pin_oe, 38'h0);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_static();
        t_commons();
        t_third();
        t_remap_off();
        end_of_test();
    end
endmodule
